// ==== common/pw_gate_pkg.sv ====
// Constants shared by the flash password and security lock gate.
// Assumes 16-bit flash byte addressing and 8-bit serial bytes.
package pw_gate_pkg;
   localparam int ADDR_W = 16;
   localparam logic [15:0] VEC_LO = 16'hFFE0;
   localparam logic [4:0] VEC_LAST = 5'h1F;
   localparam logic [7:0] ERASED = 8'hFF;
   localparam logic [15:0] USER_LO = 16'h1000;
   localparam logic [15:0] USER_HI = 16'hFEFF;
   localparam logic [7:0] LEN_MIN = 8'h08;
   localparam logic [7:0] START_MARK = 8'h3A;
   localparam logic [7:0] CMD_ERASE = 8'hF0;
   localparam logic [7:0] CMD_WRITE = 8'h30;
   localparam logic [7:0] CMD_READ = 8'h40;
   localparam logic [7:0] CMD_RAMLOAD = 8'h60;
   localparam logic [7:0] CMD_SECURE = 8'hFA;
   localparam logic [7:0] CMD_STATUS = 8'hC3;
   localparam logic [1:0] PTR_LAST = 2'h2;
   localparam int RUN_LIMIT = 3;
endpackage : pw_gate_pkg

// ==== hw/repeat_run_detect.sv ====
// Flags a received string holding RUN_MAX identical bytes in a row.
// Assumes one byte per strobe and a clear before each new string.
`timescale 1ns/1ns
`default_nettype none
module repeat_run_detect #(
   parameter int RUN_MAX = pw_gate_pkg::RUN_LIMIT
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clear,
   input wire logic byte_valid,
   input wire logic [7:0] byte_in,
   output logic run_hit
);
   import pw_gate_pkg::*;
   logic [7:0] last;
   logic [7:0] run_len;
   logic [7:0] next_last;
   logic [7:0] next_run_len;
   logic next_run_hit;

   if (RUN_MAX < 2 || RUN_MAX > 255) begin : g_bad
      $error("repeat_run_detect: RUN_MAX out of range");
   end

   always_comb begin
      next_last = last;
      next_run_len = run_len;
      next_run_hit = run_hit;
      if (clear) begin
         next_run_len = 8'h00;
         next_run_hit = 1'b0;
      end else if (byte_valid) begin
         next_last = byte_in;
         // First byte of a string always starts a fresh run
         if (run_len != 8'h00 && byte_in == last) begin
            next_run_len = run_len + 8'h01;
         end else begin
            next_run_len = 8'h01;
         end
         if (next_run_len >= 8'(RUN_MAX)) begin
            next_run_hit = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         last <= 8'h00;
         run_len <= 8'h00;
         run_hit <= 1'b0;
      end else begin
         last <= next_last;
         run_len <= next_run_len;
         run_hit <= next_run_hit;
      end
   end
endmodule : repeat_run_detect
`default_nettype wire

// ==== hw/protect_store.sv ====
// Security lock bit kept apart from user flash.
// Assumes a nonvolatile backing cell read on nv_lock and written on nv_wr.
`timescale 1ns/1ns
`default_nettype none
module protect_store (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic nv_lock,
   input wire logic set_lock,
   input wire logic clear_lock,
   output logic locked,
   output logic nv_wr,
   output logic nv_wr_data
);
   import pw_gate_pkg::*;
   logic loaded;
   logic next_loaded;
   logic next_locked;
   logic next_nv_wr;
   logic next_nv_wr_data;

   always_comb begin
      next_loaded = 1'b1;
      next_locked = locked;
      next_nv_wr = 1'b0;
      next_nv_wr_data = nv_wr_data;
      // Reset may not load a port, so the stored lock is caught after release
      if (!loaded) begin
         next_locked = nv_lock;
      end else if (set_lock) begin
         next_locked = 1'b1;
         next_nv_wr = 1'b1;
         next_nv_wr_data = 1'b1;
      end else if (clear_lock) begin
         next_locked = 1'b0;
         next_nv_wr = 1'b1;
         next_nv_wr_data = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         loaded <= 1'b0;
         locked <= 1'b1;
         nv_wr <= 1'b0;
         nv_wr_data <= 1'b0;
      end else begin
         loaded <= next_loaded;
         locked <= next_locked;
         nv_wr <= next_nv_wr;
         nv_wr_data <= next_nv_wr_data;
      end
   end
endmodule : protect_store
`default_nettype wire

// ==== hw/flash_password_security_gate.sv ====
// Blank check, password authentication and security lock gate for
// serial flash programming and debug start.
// Assumes a flash read port answering with flash_rd_valid after a request
// and an executor that pulses op_done when a granted command ends.
//
// Behaviour
// - Part is non-blank if any byte at 0xFFE0..0xFFFF differs from 0xFF.
// - Non-blank serial part runs pointer commands only after good authentication; failure idles.
// - Blank part skips string but still takes both pointers, range checked.
// - Password applies in serial mode and before debug; parallel mode unaffected.
// - Password lies in user flash 0x1000..0xFEFF, eight bytes or more.
// - Length pointer is three bytes; out of range or short length errors.
// - Compare pointer is three bytes; non-blank range 0x1000..0xFEFF-N.
// - N received bytes compared with flash from compare pointer; mismatch errors.
// - Three identical consecutive string bytes is a password error.
// - After an error, transmit nothing, ignore input until reset.
// - Erase, write, read, RAM-load and security commands need pointers.
// - Chip erase removes the password since it is plain flash data.
// - Blank write or RAM-load discards bytes until a 0x3A start mark.
// - Lock refuses parallel flash access and all serial commands except erase and status.
// - Lock lives in its own protection memory, not user flash.
// - Security-setting command sets the lock.
// - Only a chip erase through the erase command clears the lock.
// - Debug start on a non-blank part needs successful password authentication first; a blank part starts after both pointers.
// - Blank classification is reported for the status command.
`timescale 1ns/1ns
`default_nettype none
module flash_password_security_gate (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic serial_mode,
   input wire logic parallel_mode,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic on_chip_debug_req,
   input wire logic op_done,
   input wire logic chip_erase_done,
   input wire logic nv_lock,
   output logic nv_wr,
   output logic nv_wr_data,
   output logic flash_rd_en,
   output logic [pw_gate_pkg::ADDR_W-1:0] flash_rd_addr,
   input wire logic flash_rd_valid,
   input wire logic [7:0] flash_rd_data,
   output logic cmd_go,
   output logic [7:0] cmd_code,
   output logic on_chip_debug_go,
   output logic blank,
   output logic locked,
   output logic tx_allow,
   output logic par_access_ok
);
   import pw_gate_pkg::*;

   typedef enum logic [9:0] {
      ST_SCAN = 10'b00_0000_0001,
      ST_CMD = 10'b00_0000_0010,
      ST_LPTR = 10'b00_0000_0100,
      ST_CPTR = 10'b00_0000_1000,
      ST_NREAD = 10'b00_0001_0000,
      ST_STR = 10'b00_0010_0000,
      ST_SCMP = 10'b00_0100_0000,
      ST_HUNT = 10'b00_1000_0000,
      ST_BUSY = 10'b01_0000_0000,
      ST_DEAD = 10'b10_0000_0000
   } gate_state_e;

   gate_state_e state, next_state;
   logic [7:0] cnt, next_cnt;
   logic [23:0] len_ptr, next_len_ptr;
   logic [23:0] cmp_ptr, next_cmp_ptr;
   logic [7:0] pw_len, next_pw_len;
   logic [7:0] rx_hold, next_rx_hold;
   logic [7:0] next_cmd_code;
   logic is_debug, next_is_debug;
   logic dirty, next_dirty;
   logic rd_wait, next_rd_wait;
   logic next_blank;
   logic next_rd_en;
   logic [ADDR_W-1:0] next_rd_addr;
   logic next_cmd_go;
   logic next_debug_go;
   logic set_lock;
   logic run_hit;
   logic rx_take;

   function automatic logic needs_ptr(input logic [7:0] c);
      return c == CMD_ERASE || c == CMD_WRITE || c == CMD_READ ||
             c == CMD_RAMLOAD || c == CMD_SECURE;
   endfunction : needs_ptr

   function automatic logic in_user(input logic [23:0] a, input logic [15:0] hi);
      return a[23:16] == 8'h00 && a[15:0] >= USER_LO && a[15:0] <= hi;
   endfunction : in_user

   // Password checking only listens on the serial link
   assign rx_take = rx_valid && serial_mode && state != ST_DEAD;
   assign tx_allow = state != ST_DEAD;
   assign par_access_ok = parallel_mode && !locked;

   repeat_run_detect u_run (
      .core_clk(core_clk),
      .rst(rst),
      .clear(state != ST_STR && state != ST_SCMP),
      .byte_valid(state == ST_STR && rx_take),
      .byte_in(rx_data),
      .run_hit(run_hit)
   );

   protect_store u_lock (
      .core_clk(core_clk),
      .rst(rst),
      .nv_lock(nv_lock),
      .set_lock(set_lock),
      .clear_lock(chip_erase_done && cmd_code == CMD_ERASE && state == ST_BUSY),
      .locked(locked),
      .nv_wr(nv_wr),
      .nv_wr_data(nv_wr_data)
   );

   assign set_lock = cmd_go && cmd_code == CMD_SECURE;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_len_ptr = len_ptr;
      next_cmp_ptr = cmp_ptr;
      next_pw_len = pw_len;
      next_rx_hold = rx_hold;
      next_cmd_code = cmd_code;
      next_is_debug = is_debug;
      next_dirty = dirty;
      next_blank = blank;
      next_rd_wait = rd_wait && !flash_rd_valid;
      next_rd_en = 1'b0;
      next_rd_addr = flash_rd_addr;
      next_cmd_go = 1'b0;
      next_debug_go = 1'b0;
      case (state)
         ST_SCAN: begin
            if (!rd_wait) begin
               next_rd_en = 1'b1;
               next_rd_wait = 1'b1;
               next_rd_addr = VEC_LO + {11'h000, cnt[4:0]};
            end
            if (flash_rd_valid) begin
               next_dirty = dirty || flash_rd_data != ERASED;
               next_rd_wait = 1'b0;
               next_rd_en = 1'b0;
               if (cnt[4:0] == VEC_LAST) begin
                  next_blank = !next_dirty;
                  next_cnt = 8'h00;
                  next_state = ST_CMD;
               end else begin
                  next_cnt = cnt + 8'h01;
               end
            end
         end
         ST_CMD: begin
            next_cnt = 8'h00;
            if (rx_take) begin
               next_cmd_code = rx_data;
               next_is_debug = 1'b0;
               // Under lock only erase and status stay usable
               if (locked && rx_data != CMD_ERASE && rx_data != CMD_STATUS) begin
                  next_state = ST_CMD;
               end else if (needs_ptr(rx_data)) begin
                  next_state = ST_LPTR;
               end else begin
                  next_cmd_go = 1'b1;
                  next_state = ST_BUSY;
               end
            end else if (on_chip_debug_req && serial_mode) begin
               next_is_debug = 1'b1;
               next_state = ST_LPTR;
            end
         end
         ST_LPTR: begin
            if (rx_take) begin
               next_len_ptr = {len_ptr[15:0], rx_data};
               next_cnt = cnt + 8'h01;
               if (cnt[1:0] == PTR_LAST) begin
                  next_cnt = 8'h00;
                  next_state = ST_CPTR;
               end
            end
         end
         ST_CPTR: begin
            if (rx_take) begin
               next_cmp_ptr = {cmp_ptr[15:0], rx_data};
               next_cnt = cnt + 8'h01;
               if (cnt[1:0] == PTR_LAST) begin
                  next_cnt = 8'h00;
                  if (!in_user(len_ptr, USER_HI)) begin
                     next_state = ST_DEAD;
                  end else if (!blank) begin
                     next_state = ST_NREAD;
                  end else if (!in_user(next_cmp_ptr, USER_HI)) begin
                     next_state = ST_DEAD;
                  end else if (!is_debug &&
                               (cmd_code == CMD_WRITE || cmd_code == CMD_RAMLOAD)) begin
                     next_state = ST_HUNT;
                  end else begin
                     // Blank erase expects no string at all
                     next_cmd_go = !is_debug;
                     next_debug_go = is_debug;
                     next_state = is_debug ? ST_CMD : ST_BUSY;
                  end
               end
            end
         end
         ST_NREAD: begin
            if (!rd_wait) begin
               next_rd_en = 1'b1;
               next_rd_wait = 1'b1;
               next_rd_addr = len_ptr[15:0];
            end
            if (flash_rd_valid) begin
               next_rd_en = 1'b0;
               next_pw_len = flash_rd_data;
               if (flash_rd_data < LEN_MIN) begin
                  next_state = ST_DEAD;
               end else if (!in_user(cmp_ptr, USER_HI - {8'h00, flash_rd_data})) begin
                  next_state = ST_DEAD;
               end else begin
                  next_state = ST_STR;
               end
            end
         end
         ST_STR: begin
            if (rx_take) begin
               next_rx_hold = rx_data;
               next_rd_en = 1'b1;
               next_rd_wait = 1'b1;
               next_rd_addr = cmp_ptr[15:0] + {8'h00, cnt};
               next_state = ST_SCMP;
            end
         end
         ST_SCMP: begin
            if (flash_rd_valid) begin
               if (flash_rd_data != rx_hold || run_hit) begin
                  next_state = ST_DEAD;
               end else if (cnt + 8'h01 == pw_len) begin
                  next_cnt = 8'h00;
                  next_cmd_go = !is_debug;
                  next_debug_go = is_debug;
                  next_state = is_debug ? ST_CMD : ST_BUSY;
               end else begin
                  next_cnt = cnt + 8'h01;
                  next_state = ST_STR;
               end
            end
         end
         ST_HUNT: begin
            if (rx_take && rx_data == START_MARK) begin
               next_cmd_go = 1'b1;
               next_state = ST_BUSY;
            end
         end
         ST_BUSY: begin
            // Rescan, since a chip erase leaves the part blank
            if (op_done) begin
               next_dirty = 1'b0;
               next_cnt = 8'h00;
               next_state = ST_SCAN;
            end
         end
         ST_DEAD: begin
            next_state = ST_DEAD;
         end
         default: begin
            next_state = ST_DEAD;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= ST_SCAN;
         cnt <= 8'h00;
         len_ptr <= 24'h00_0000;
         cmp_ptr <= 24'h00_0000;
         pw_len <= 8'h00;
         rx_hold <= 8'h00;
         cmd_code <= 8'h00;
         is_debug <= 1'b0;
         dirty <= 1'b0;
         blank <= 1'b0;
         rd_wait <= 1'b0;
         flash_rd_en <= 1'b0;
         flash_rd_addr <= 16'h0000;
         cmd_go <= 1'b0;
         on_chip_debug_go <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         len_ptr <= next_len_ptr;
         cmp_ptr <= next_cmp_ptr;
         pw_len <= next_pw_len;
         rx_hold <= next_rx_hold;
         cmd_code <= next_cmd_code;
         is_debug <= next_is_debug;
         dirty <= next_dirty;
         blank <= next_blank;
         rd_wait <= next_rd_wait;
         flash_rd_en <= next_rd_en;
         flash_rd_addr <= next_rd_addr;
         cmd_go <= next_cmd_go;
         on_chip_debug_go <= next_debug_go;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   chk_dead_stays_dead: assert property (state == ST_DEAD |=> state == ST_DEAD [*4])
      else $error("idle after error was left");
   chk_dead_no_grant: assert property (state == ST_DEAD |-> !cmd_go && !tx_allow)
      else $error("grant or transmit after error");
   chk_auth_before_go: assert property (cmd_go && needs_ptr(cmd_code) && !blank
      |-> $past(state) == ST_SCMP)
      else $error("protected command granted without string check");
   chk_lock_refuses: assert property (state == ST_CMD && rx_take && locked
      && rx_data == CMD_READ |=> state == ST_CMD && !cmd_go)
      else $error("read accepted while locked");
   chk_short_length: assert property (state == ST_NREAD && flash_rd_valid
      && flash_rd_data < LEN_MIN |=> state == ST_DEAD)
      else $error("short length not rejected");
   chk_byte_mismatch: assert property (state == ST_SCMP && flash_rd_valid
      && flash_rd_data != rx_hold |=> state == ST_DEAD)
      else $error("mismatching byte not rejected");
   chk_hunt_discard: assert property (state == ST_HUNT && rx_take
      && rx_data != START_MARK |=> state == ST_HUNT && !cmd_go)
      else $error("byte before start mark not discarded");
   chk_secure_locks: assert property (cmd_go && cmd_code == CMD_SECURE
      |-> ##[1:2] locked)
      else $error("security command did not lock");
   chk_debug_auth: assert property ($rose(on_chip_debug_go)
      |-> $past(state) == ST_SCMP || ($past(state) == ST_CPTR && blank))
      else $error("debug start without authentication");
   chk_scan_blank: assert property (state == ST_SCAN && flash_rd_valid
      && flash_rd_data != ERASED |=> dirty)
      else $error("written vector byte missed");

   cov_auth_grant: cover property (state == ST_SCMP ##1 cmd_go);
   cov_blank_hunt: cover property (state == ST_HUNT ##1 cmd_go);
   cov_error_idle: cover property (state == ST_SCMP ##1 state == ST_DEAD);
   cov_lock_set: cover property (set_lock ##[1:2] locked);
endmodule : flash_password_security_gate
`default_nettype wire

// ==== verification/flash_model.sv ====
// Behavioural flash read port facing the gate: byte array with settable latency.
// Assumes one outstanding read at a time, as the gate promises.
`timescale 1ns/1ns
`default_nettype none
module flash_model (
   input wire logic core_clk,
   input wire logic rd_en,
   input wire logic [15:0] rd_addr,
   output logic rd_valid,
   output logic [7:0] rd_data
);
   logic [7:0] mem [0:65535];
   int lat = 1;
   int cnt = 0;
   logic [15:0] addr_q = 16'h0000;
   logic [7:0] last = 8'h00;
   initial begin
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end
   always @(posedge core_clk) begin
      rd_valid <= 1'b0;
      // Stale data is never left on the bus, so a late sample cannot pass
      rd_data <= ~last;
      if (rd_en && lat <= 1) begin
         rd_valid <= 1'b1;
         rd_data <= mem[rd_addr];
         last <= mem[rd_addr];
      end else if (rd_en) begin
         addr_q <= rd_addr;
         cnt <= lat - 1;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            rd_valid <= 1'b1;
            rd_data <= mem[addr_q];
            last <= mem[addr_q];
         end
      end
   end
endmodule : flash_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the flash password and security lock gate.
// Assumes the flash model as partner; the bench plays host and executor.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import pw_gate_pkg::*;
   localparam logic [23:0] LP = 24'h00_1800;
   localparam logic [23:0] CP = 24'h00_2000;
   logic core_clk, rst, serial_mode, parallel_mode, rx_valid, on_chip_debug_req;
   logic op_done, chip_erase_done, flash_rd_valid, flash_rd_en;
   // Single driver: the protection cell only changes on the gate's write pulse
   logic nv_cell = 1'b0;
   logic [7:0] rx_data, flash_rd_data, cmd_code;
   logic nv_wr, nv_wr_data, cmd_go, on_chip_debug_go, blank, locked, tx_allow, par_access_ok;
   logic [ADDR_W-1:0] flash_rd_addr;
   logic [7:0] last_code = 8'h00;
   logic [7:0] str [0:7];
   int miscompares = 0;
   int checks_done = 0;
   int gos = 0;
   int dbg_gos = 0;

   flash_password_security_gate flash_password_security_gate_inst (
      .core_clk, .rst, .serial_mode, .parallel_mode, .rx_valid, .rx_data,
      .on_chip_debug_req, .op_done, .chip_erase_done, .nv_lock(nv_cell), .nv_wr,
      .nv_wr_data, .flash_rd_en, .flash_rd_addr, .flash_rd_valid, .flash_rd_data,
      .cmd_go, .cmd_code, .on_chip_debug_go, .blank, .locked, .tx_allow, .par_access_ok);
   flash_model flash_model_inst (.core_clk(core_clk), .rd_en(flash_rd_en),
      .rd_addr(flash_rd_addr), .rd_valid(flash_rd_valid), .rd_data(flash_rd_data));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Protection cell survives resets, like the real separate memory
   always @(posedge core_clk) begin
      if (cmd_go) begin
         gos <= gos + 1;
         last_code <= cmd_code;
      end
      if (on_chip_debug_go) dbg_gos <= dbg_gos + 1;
      if (nv_wr) nv_cell <= nv_wr_data;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   task automatic wait_scan();
      int n;
      n = 0;
      for (int i = 0; i < 800 && n < 32; i++) begin
         @(negedge core_clk);
         if (flash_rd_en) n++;
      end
      if (n < 32) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, 32);
         wrap_up();
      end
      check(flash_rd_addr, 16'hFFFF);
      repeat (flash_model_inst.lat + 4) @(negedge core_clk);
   endtask : wait_scan

   task automatic do_reset();
      rst = 1'b1;
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      wait_scan();
   endtask : do_reset

   // Gap leaves room for the flash compare of each string byte
   task automatic send(input logic [7:0] b);
      rx_data = b;
      rx_valid = 1'b1;
      @(negedge core_clk);
      rx_valid = 1'b0;
      repeat (flash_model_inst.lat + 4) @(negedge core_clk);
   endtask : send

   task automatic ptr(input logic [23:0] a);
      send(a[23:16]);
      send(a[15:8]);
      send(a[7:0]);
   endtask : ptr

   task automatic auth(input logic [7:0] cmd, input logic [23:0] lp, input logic [23:0] cp,
                       input int n, input bit dbg);
      if (dbg) begin
         on_chip_debug_req = 1'b1;
         @(negedge core_clk);
         on_chip_debug_req = 1'b0;
         repeat (4) @(negedge core_clk);
      end else begin
         send(cmd);
      end
      ptr(lp);
      ptr(cp);
      for (int i = 0; i < n; i++) send(str[i]);
      repeat (4) @(negedge core_clk);
   endtask : auth

   task automatic finish_op(input bit erase);
      chip_erase_done = erase;
      @(negedge core_clk);
      chip_erase_done = 1'b0;
      op_done = 1'b1;
      @(negedge core_clk);
      op_done = 1'b0;
      wait_scan();
   endtask : finish_op

   task automatic expect_dead(input logic [23:0] lp, input logic [23:0] cp, input int n);
      int g0;
      g0 = gos;
      auth(CMD_READ, lp, cp, n, 1'b0);
      check(16'(gos - g0), 16'h0000);
      check(tx_allow, 16'h0000);
      send(CMD_STATUS);
      check(16'(gos - g0), 16'h0000);
      do_reset();
   endtask : expect_dead

   task automatic t_blank();
      int g0;
      do_reset();
      check(blank, 16'h0001);
      g0 = gos;
      send(CMD_STATUS);
      check(16'(gos - g0), 16'h0001);
      check(last_code, CMD_STATUS);
      finish_op(1'b0);
      g0 = gos;
      auth(CMD_ERASE, LP, 24'h00_FEFF, 0, 1'b0);
      check(16'(gos - g0), 16'h0001);
      finish_op(1'b0);
      g0 = gos;
      auth(CMD_WRITE, 24'h00_1000, 24'h00_1000, 0, 1'b0);
      send(8'h55);
      check(16'(gos - g0), 16'h0000);
      send(START_MARK);
      check(16'(gos - g0), 16'h0001);
      check(last_code, CMD_WRITE);
      finish_op(1'b0);
      expect_dead(LP, 24'h00_FF00, 0);
      $display("test blank done");
   endtask : t_blank

   task automatic t_pass();
      logic [7:0] codes [0:2];
      int g0;
      codes = '{CMD_WRITE, CMD_READ, CMD_RAMLOAD};
      flash_model_inst.mem[16'hFFFF] = 8'h00;
      do_reset();
      check(blank, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         g0 = gos;
         auth(codes[i], LP, CP, 8, 1'b0);
         check(16'(gos - g0), 16'h0001);
         check(last_code, codes[i]);
         finish_op(1'b0);
      end
      g0 = dbg_gos;
      auth(8'h00, LP, CP, 8, 1'b1);
      check(16'(dbg_gos - g0), 16'h0001);
      parallel_mode = 1'b1;
      @(negedge core_clk);
      check(par_access_ok, 16'h0001);
      $display("test password done");
   endtask : t_pass

   task automatic t_errors();
      str[3] = ~str[3];
      expect_dead(LP, CP, 8);
      str[3] = ~str[3];
      expect_dead(24'h01_1800, CP, 8);
      expect_dead(24'h00_0FFF, CP, 8);
      flash_model_inst.mem[16'h1900] = 8'h07;
      expect_dead(24'h00_1900, CP, 8);
      expect_dead(LP, 24'h00_FEF8, 8);
      expect_dead(LP, 24'h00_0FFF, 8);
      str[2] = str[0];
      flash_model_inst.mem[16'h2002] = str[0];
      expect_dead(LP, CP, 8);
      // Put the legal password back, later scenarios authenticate with it
      str[2] = str[3] - 8'h01;
      flash_model_inst.mem[16'h2002] = str[2];
      $display("test errors done");
   endtask : t_errors

   task automatic t_lock();
      int g0;
      g0 = gos;
      auth(CMD_SECURE, LP, CP, 8, 1'b0);
      check(16'(gos - g0), 16'h0001);
      check(locked, 16'h0001);
      check(nv_cell, 16'h0001);
      finish_op(1'b0);
      check(par_access_ok, 16'h0000);
      do_reset();
      check(locked, 16'h0001);
      g0 = gos;
      send(CMD_READ);
      check(16'(gos - g0), 16'h0000);
      auth(CMD_ERASE, LP, CP, 8, 1'b0);
      check(last_code, CMD_ERASE);
      for (int i = 0; i < 65536; i++) flash_model_inst.mem[i] = ERASED;
      finish_op(1'b1);
      check(locked, 16'h0000);
      check(blank, 16'h0001);
      check(par_access_ok, 16'h0001);
      // Reset default is locked, so only a cleared cell shows the load
      do_reset();
      check(locked, 16'h0000);
      $display("test lock done");
   endtask : t_lock

   initial begin
      repeat (100000) @(posedge core_clk);
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 0, 1);
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      serial_mode = 1'b1;
      parallel_mode = 1'b0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      on_chip_debug_req = 1'b0;
      op_done = 1'b0;
      chip_erase_done = 1'b0;
      for (int i = 0; i < 65536; i++) flash_model_inst.mem[i] = ERASED;
      for (int i = 0; i < 8; i++) str[i] = 8'h40 + 8'(i);
      // Two equal bytes in a row stay legal
      str[1] = str[0];
      flash_model_inst.mem[16'h1800] = 8'h08;
      for (int i = 0; i < 8; i++) flash_model_inst.mem[16'h2000 + i] = str[i];
      t_blank();
      flash_model_inst.lat = 3;
      t_pass();
      t_errors();
      t_lock();
      wrap_up();
   end
endmodule : testbench
`default_nettype wire
